// ===== inc/rcs_pkg.sv
package rcs_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned DET_WINDOW_NS   = 10000;
  localparam int unsigned DET_WINDOW_CYC  = DET_WINDOW_NS / CLK_PERIOD_NS;
  localparam int unsigned DET_MIN_TOGGLES = 16;
  localparam int unsigned NUM_SLOTS       = 8;
  localparam int unsigned TRIG_LINES      = 8;
  localparam int unsigned NUM_SRC         = 3;
  localparam int unsigned SRC_TIMING      = 0;
  localparam int unsigned SRC_COAX        = 1;
  localparam int unsigned SRC_OSC         = 2;
  localparam logic [7:0]  TOG_RESET       = 8'h00;
  localparam logic [NUM_SRC-1:0] PRESENT_RESET = 3'h0;

  typedef enum logic [1:0] {
    REF_INTERNAL,
    REF_COAX,
    REF_TIMING
  } rcs_ref_sel_type;

  typedef struct packed {
    logic osc_running_lamp;
    logic ext_ref_present_lamp;
    logic pll_locked_lamp;
  } rcs_lamps_type;
endpackage : rcs_pkg

// ===== design/rcs_ref_clock_select.sv
`timescale 1ns/10ps
module rcs_ref_clock_select
  import rcs_pkg::*;
#(
  parameter int unsigned SLOTS   = NUM_SLOTS,
  parameter int unsigned TRIGS   = TRIG_LINES,
  parameter int unsigned WIN_CYC = DET_WINDOW_CYC,
  parameter int unsigned MIN_TOG = DET_MIN_TOGGLES
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic             timing_clk_in,
  input  wire logic             coax_clk_in,
  input  wire logic             osc_clk_in,
  input  wire logic             pll_lock_in,
  input  wire logic [SLOTS*TRIGS-1:0] slot_trig_drive,
  input  wire logic [SLOTS-1:0] slot_local_out,
  output logic      [SLOTS-1:0] slot_clk10,
  output logic      [SLOTS-1:0] slot_clk100_en,
  output logic                  pll_ref,
  output logic                  pll_use_ext,
  output logic                  ref_coax_out,
  output rcs_lamps_type         lamps,
  output rcs_ref_sel_type       ref_sel,
  output logic      [TRIGS-1:0] trig_bus,
  output logic      [SLOTS-1:0] local_from_left,
  output logic      [SLOTS-1:0] local_from_right
);

  localparam int unsigned PINS = NUM_SRC + 1 + SLOTS*TRIGS + SLOTS;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PINS-1:0] meta_r;
  logic [PINS-1:0] sync_r;
  logic [PINS-1:0] pins_in;

  assign pins_in = {slot_local_out, slot_trig_drive, pll_lock_in,
                    osc_clk_in, coax_clk_in, timing_clk_in};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (clk_en) begin
      meta_r <= pins_in;
      sync_r <= meta_r;
    end
  end

  logic [NUM_SRC-1:0]     src_lvl;
  logic                   lock_lvl;
  logic [SLOTS*TRIGS-1:0] trig_lvl;
  logic [SLOTS-1:0]       local_lvl;

  assign src_lvl   = sync_r[NUM_SRC-1:0];
  assign lock_lvl  = sync_r[NUM_SRC];
  assign trig_lvl  = sync_r[NUM_SRC+1 +: SLOTS*TRIGS];
  assign local_lvl = sync_r[NUM_SRC+1+SLOTS*TRIGS +: SLOTS];

  ////////////////////////////////////////////////////////////////////////////
  // activity detection and source choice
  logic [15:0]             win_r,     win_nxt;
  logic [NUM_SRC-1:0]      prev_r,    prev_nxt;
  logic [NUM_SRC-1:0][7:0] tog_r,     tog_nxt;
  logic [NUM_SRC-1:0]      present_r, present_nxt;
  rcs_ref_sel_type         sel_r,     sel_nxt;
  logic                    div_r,     div_nxt;
  logic                    ref_lvl_r, ref_lvl_nxt;
  logic                    win_end;

  assign win_end = (win_r == 16'(WIN_CYC - 1));

  always_comb begin
    win_nxt     = win_end ? 16'h0000 : win_r + 16'h0001;
    prev_nxt    = src_lvl;
    tog_nxt     = tog_r;
    present_nxt = present_r;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (win_end) begin
        present_nxt[i] = (tog_r[i] >= 8'(MIN_TOG));
        tog_nxt[i]     = TOG_RESET;
      end else if (src_lvl[i] != prev_r[i] && tog_r[i] != 8'hff) begin
        tog_nxt[i] = tog_r[i] + 8'h01;
      end
    end
    if (present_r[SRC_TIMING]) begin
      sel_nxt = REF_TIMING;
    end else if (present_r[SRC_COAX]) begin
      sel_nxt = REF_COAX;
    end else begin
      sel_nxt = REF_INTERNAL;
    end
    div_nxt = ~div_r;
    unique case (sel_r)
      REF_TIMING:   ref_lvl_nxt = src_lvl[SRC_TIMING];
      REF_COAX:     ref_lvl_nxt = src_lvl[SRC_COAX];
      REF_INTERNAL: ref_lvl_nxt = div_r;
      default:      ref_lvl_nxt = div_r;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      win_r     <= 16'h0000;
      prev_r    <= '0;
      tog_r     <= '0;
      present_r <= PRESENT_RESET;
      sel_r     <= REF_INTERNAL;
      div_r     <= 1'b0;
      ref_lvl_r <= 1'b0;
    end else if (clk_en) begin
      win_r     <= win_nxt;
      prev_r    <= prev_nxt;
      tog_r     <= tog_nxt;
      present_r <= present_nxt;
      sel_r     <= sel_nxt;
      div_r     <= div_nxt;
      ref_lvl_r <= ref_lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // distribution, pll control, lamps, trigger and local bus
  logic [SLOTS-1:0] clk10_r,   clk10_nxt;
  logic [SLOTS-1:0] c100_r,    c100_nxt;
  logic             pref_r,    pref_nxt;
  logic             pext_r,    pext_nxt;
  logic             coax_r,    coax_nxt;
  rcs_lamps_type    lamps_r,   lamps_nxt;
  logic [TRIGS-1:0] trig_r,    trig_nxt;
  logic [SLOTS-1:0] lleft_r,   lleft_nxt;
  logic [SLOTS-1:0] lright_r,  lright_nxt;

  // high while an external source drives the reference
  function automatic logic is_ext(input rcs_ref_sel_type s);
    return (s != REF_INTERNAL);
  endfunction : is_ext

  always_comb begin
    for (int s = 0; s < SLOTS; s++) begin
      clk10_nxt[s]  = ref_lvl_r;
      c100_nxt[s]   = lock_lvl | !is_ext(sel_r);
      lleft_nxt[s]  = (s == 0) ? 1'b0 : local_lvl[s-1];
      lright_nxt[s] = (s == SLOTS-1) ? 1'b0 : local_lvl[s+1];
    end
    trig_nxt = '0;
    for (int s = 0; s < SLOTS; s++) begin
      trig_nxt = trig_nxt | trig_lvl[s*TRIGS +: TRIGS];
    end
    pref_nxt = ref_lvl_r;
    pext_nxt = is_ext(sel_r);
    coax_nxt = ref_lvl_r;
    lamps_nxt.osc_running_lamp     = present_r[SRC_OSC];
    lamps_nxt.ext_ref_present_lamp = present_r[SRC_TIMING] | present_r[SRC_COAX];
    lamps_nxt.pll_locked_lamp      = lock_lvl & is_ext(sel_r);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk10_r  <= '0;
      c100_r   <= '0;
      pref_r   <= 1'b0;
      pext_r   <= 1'b0;
      coax_r   <= 1'b0;
      lamps_r  <= '0;
      trig_r   <= '0;
      lleft_r  <= '0;
      lright_r <= '0;
    end else if (clk_en) begin
      clk10_r  <= clk10_nxt;
      c100_r   <= c100_nxt;
      pref_r   <= pref_nxt;
      pext_r   <= pext_nxt;
      coax_r   <= coax_nxt;
      lamps_r  <= lamps_nxt;
      trig_r   <= trig_nxt;
      lleft_r  <= lleft_nxt;
      lright_r <= lright_nxt;
    end
  end

  assign slot_clk10       = clk10_r;
  assign slot_clk100_en   = c100_r;
  assign pll_ref          = pref_r;
  assign pll_use_ext      = pext_r;
  assign ref_coax_out     = coax_r;
  assign lamps            = lamps_r;
  assign ref_sel          = sel_r;
  assign trig_bus         = trig_r;
  assign local_from_left  = lleft_r;
  assign local_from_right = lright_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence quiet_window;
    clk_en && win_end && tog_r[SRC_COAX] < 8'(MIN_TOG);
  endsequence

  sequence busy_window;
    clk_en && win_end && tog_r[SRC_COAX] >= 8'(MIN_TOG);
  endsequence

  AST_TIMING_WINS: assert property (clk_en && present_r[SRC_TIMING]
    |=> sel_r == REF_TIMING)
    else $error("timing slot clock not selected");
  AST_COAX_ONLY: assert property (clk_en && !present_r[SRC_TIMING] && present_r[SRC_COAX]
    |=> sel_r == REF_COAX)
    else $error("coax clock not selected");
  AST_INTERNAL: assert property (clk_en && present_r[1:0] == 2'b00
    |=> sel_r == REF_INTERNAL)
    else $error("internal reference not selected");
  AST_MUX_INT: assert property (clk_en && sel_r == REF_INTERNAL
    |=> ref_lvl_r == $past(div_r))
    else $error("internal divider not forwarded");
  AST_SLOT_FANOUT: assert property (clk_en |=> slot_clk10 == {SLOTS{$past(ref_lvl_r)}})
    else $error("slot clocks differ from reference");
  AST_PLL_EXT: assert property (clk_en |=> pll_use_ext == ($past(sel_r) != REF_INTERNAL))
    else $error("pll reference choice wrong");
  AST_EXT_LAMP: assert property (clk_en
    |=> lamps.ext_ref_present_lamp == $past(present_r[SRC_TIMING] | present_r[SRC_COAX]))
    else $error("external lamp wrong");
  AST_COAX_OUT: assert property (clk_en |=> ref_coax_out == $past(ref_lvl_r))
    else $error("rear output differs from pll reference");
  AST_DROP: assert property (quiet_window |=> !present_r[SRC_COAX])
    else $error("quiet source kept as present");
  AST_ACCEPT: assert property (busy_window |=> present_r[SRC_COAX])
    else $error("toggling source not accepted");

endmodule : rcs_ref_clock_select

// ===== dv/rcs_src_model.sv
`timescale 1ns/10ps
module rcs_src_model (
  input  wire logic timing_on,
  input  wire logic coax_on,
  input  wire logic osc_on,
  input  wire logic lock_on,
  output logic      timing_clk_in,
  output logic      coax_clk_in,
  output logic      osc_clk_in,
  output logic      pll_lock_in
);
  logic ph = 1'b0;
  logic po = 1'b0;
  // 10 mhz timing and coax sources, 74 ns period osc source, phase unrelated to clk_sys
  initial begin
    #12;
    forever #50 ph = ~ph;
  end
  initial begin
    forever #37 po = ~po;
  end
  // an absent clock stands still low
  assign timing_clk_in = timing_on & ph;
  assign coax_clk_in   = coax_on & ph;
  assign osc_clk_in    = osc_on & po;
  assign pll_lock_in   = lock_on;
endmodule : rcs_src_model

// ===== dv/test_ref_clock_source_select.sv
`timescale 1ns/10ps
module test_ref_clock_source_select;
  import rcs_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b0;
  logic t_on = 1'b0, c_on = 1'b0, o_on = 1'b0, l_on = 1'b0;
  logic timing_clk_in, coax_clk_in, osc_clk_in, pll_lock_in;
  logic [63:0] slot_trig_drive = '0;
  logic [7:0]  slot_local_out = '0;
  logic [7:0]  slot_clk10, slot_clk100_en, trig_bus, local_from_left, local_from_right;
  logic pll_ref, pll_use_ext, ref_coax_out;
  rcs_lamps_type   lamps;
  rcs_ref_sel_type ref_sel;
  int bad_count = 0;
  int n_tests = 0;
  always #25 clk_sys = ~clk_sys;
  rcs_src_model rcs_src_model_i (.timing_on(t_on), .coax_on(c_on), .osc_on(o_on),
    .lock_on(l_on), .timing_clk_in(timing_clk_in), .coax_clk_in(coax_clk_in),
    .osc_clk_in(osc_clk_in), .pll_lock_in(pll_lock_in));
  rcs_ref_clock_select #(.WIN_CYC(20), .MIN_TOG(4)) rcs_ref_clock_select_i (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .timing_clk_in(timing_clk_in),
    .coax_clk_in(coax_clk_in), .osc_clk_in(osc_clk_in), .pll_lock_in(pll_lock_in),
    .slot_trig_drive(slot_trig_drive), .slot_local_out(slot_local_out),
    .slot_clk10(slot_clk10), .slot_clk100_en(slot_clk100_en), .pll_ref(pll_ref),
    .pll_use_ext(pll_use_ext), .ref_coax_out(ref_coax_out), .lamps(lamps),
    .ref_sel(ref_sel), .trig_bus(trig_bus), .local_from_left(local_from_left),
    .local_from_right(local_from_right));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // sources set, then 70 cycles (three and a half detection windows) to settle
  task automatic src(input logic t, input logic c, input logic l);
    @(posedge clk_sys);
    t_on <= t;
    c_on <= c;
    l_on <= l;
    cyc(70);
  endtask : src
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_select;
    src(1'b0, 1'b0, 1'b0);
    chk(ref_sel, REF_INTERNAL);
    chk(lamps, 3'b100);
    chk({pll_use_ext, slot_clk100_en}, 9'h0ff);
    src(1'b0, 1'b1, 1'b0);
    chk(ref_sel, REF_COAX);
    chk({lamps, pll_use_ext}, 4'b1101);
    @(posedge clk_sys);
    c_on <= 1'b0;
    cyc(6);
    chk({slot_clk10, pll_ref, ref_coax_out}, 10'h000);
    src(1'b0, 1'b1, 1'b1);
    chk({lamps, slot_clk100_en}, 11'h7ff);
    src(1'b1, 1'b1, 1'b1);
    chk(ref_sel, REF_TIMING);
    @(posedge clk_sys);
    t_on <= 1'b0;
    cyc(6);
    chk({slot_clk10, pll_ref, ref_coax_out}, 10'h000);
    src(1'b1, 1'b0, 1'b0);
    chk({ref_sel, lamps}, {REF_TIMING, 3'b110});
    src(1'b0, 1'b0, 1'b0);
    chk({ref_sel, pll_use_ext, lamps}, 6'b000100);
  endtask : t_select
  task automatic t_clocks;
    int n;
    logic p;
    n = 0;
    p = slot_clk10[0];
    repeat (20) begin
      cyc(1);
      chk(slot_clk10, {8{slot_clk10[0]}});
      chk(ref_coax_out, pll_ref);
      n += (slot_clk10[0] != p);
      p = slot_clk10[0];
    end
    chk(n, 20);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    cyc(1);
    p = slot_clk10[0];
    cyc(4);
    chk(slot_clk10[0], p);
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask : t_clocks
  task automatic t_buses;
    @(posedge clk_sys);
    slot_trig_drive[29] <= 1'b1;
    slot_trig_drive[56] <= 1'b1;
    slot_local_out <= 8'h81;
    cyc(5);
    chk(trig_bus, 8'h21);
    chk({local_from_left, local_from_right}, 16'h0240);
    @(posedge clk_sys);
    slot_trig_drive <= '0;
    slot_local_out <= 8'h04;
    cyc(5);
    chk({trig_bus, local_from_left, local_from_right}, 24'h000802);
  endtask : t_buses
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    chk({slot_clk10, slot_clk100_en, pll_use_ext, lamps, ref_sel}, 22'h0);
    @(posedge clk_sys);
    rstn <= 1'b1;
    clk_en <= 1'b1;
    o_on <= 1'b1;
    t_select();
    t_clocks();
    t_buses();
    end_sim();
  end
  initial begin
    #(1500 * 50);
    bad_count++;
    end_sim();
  end
endmodule : test_ref_clock_source_select
